// ---- common/burst_crc_pkg.sv ----
package burst_crc_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB)
  // ==========================================================================
  localparam logic [7:0] ADDR_BURST_CFG  = 8'h00;
  localparam logic [7:0] ADDR_CRC_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_CRC_CHECK  = 8'h08;
  localparam logic [7:0] ADDR_ARRAY_CRC  = 8'h0c;
  localparam logic [7:0] ADDR_BURST_STAT = 8'h10;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int          WRAP_ON_BIT      = 4;
  localparam int          WRAP_LEN_LSB     = 0;
  localparam int          CRC_OFF_BIT      = 0;
  localparam logic [31:0] CRC_CHECK_RESET  = 32'h0fffffff;
  localparam logic [31:0] ARRAY_CRC_RESET  = 32'h00000000;
  localparam logic [31:0] CRC_POLY         = 32'h04c11db7;
  localparam logic [31:0] ERR_ADDR_DATA    = 32'h00000000;

  // ==========================================================================
  // Burst stream
  // ==========================================================================
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W     = 32;

  typedef enum logic [1:0] {
    WRAP_8  = 2'b00,
    WRAP_16 = 2'b01,
    WRAP_32 = 2'b10,
    WRAP_64 = 2'b11
  } wrap_len_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_DRAIN = 2'b11
  } burst_state_e;

endpackage : burst_crc_pkg

// ---- logic/byte_fifo.sv ----
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wrPtr_r;
  logic [PW:0]      rdPtr_r;
  logic             push;
  logic             pop;

  // Full when the pointers differ only in the wrap bit.
  assign inReady  = (wrPtr_r[PW-1:0] != rdPtr_r[PW-1:0]) || (wrPtr_r[PW] == rdPtr_r[PW]);
  assign outValid = (wrPtr_r != rdPtr_r);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_r[PW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_r[PW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end

endmodule : byte_fifo

// ---- logic/iface_crc_unit.sv ----
module iface_crc_unit (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        crcOff,
  input  wire logic        byteValid,
  input  wire logic [7:0]  byteData,
  output logic      [31:0] crcValue
);

  // ==========================================================================
  // Byte-wise CRC-32 update, MSB first
  // ==========================================================================
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ burst_crc_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      crcValue <= burst_crc_pkg::CRC_CHECK_RESET;
    end else if (byteValid && !crcOff) begin
      crcValue <= crc_step(crcValue, byteData);
    end
  end

endmodule : iface_crc_unit

// ---- logic/burst_wrap_and_crc_regs.sv ----
module burst_wrap_and_crc_regs (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Burst request
  input  wire logic        burstStart,
  input  wire logic [31:0] burstAddr,
  input  wire logic        burstStop,
  // Array read port
  output logic      [31:0] memAddr,
  output logic             memRead,
  input  wire logic [7:0]  memData,
  // Byte stream to the link
  output logic      [7:0]  outByte,
  output logic             outValid,
  input  wire logic        outReady,
  output logic      [31:0] outAddr,
  // Interface traffic seen by the CRC
  input  wire logic        linkByteValid,
  input  wire logic [7:0]  linkByte,
  // Array CRC result from the integrity engine
  input  wire logic        arrayCrcLoad,
  input  wire logic [31:0] arrayCrcIn
);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic                         burstWrapOn_r;
  burst_crc_pkg::wrap_len_e     burstWrapLengthSel_r;
  logic                         ifaceCrcOffSelect_r;
  logic [31:0]                  arrayIntegrityCrc_r;
  logic [31:0]                  ifaceCrcCheckValue;
  logic                         wrEn;
  logic                         rdEn;
  logic                         addrHit;
  logic [4:0]                   regSel;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;

  // ==========================================================================
  // Register decode
  // ==========================================================================
  localparam int SEL_CFG    = 0;
  localparam int SEL_ENABLE = 1;
  localparam int SEL_CHECK  = 2;
  localparam int SEL_ARRAY  = 3;
  localparam int SEL_STAT   = 4;

  // One-hot select shared by the write strobes and the error answer.
  function automatic logic [4:0] reg_sel(input logic [7:0] a);
    logic [4:0] s;
    s = 5'h00;
    unique case (a)
      burst_crc_pkg::ADDR_BURST_CFG:  s[SEL_CFG]    = 1'b1;
      burst_crc_pkg::ADDR_CRC_ENABLE: s[SEL_ENABLE] = 1'b1;
      burst_crc_pkg::ADDR_CRC_CHECK:  s[SEL_CHECK]  = 1'b1;
      burst_crc_pkg::ADDR_ARRAY_CRC:  s[SEL_ARRAY]  = 1'b1;
      burst_crc_pkg::ADDR_BURST_STAT: s[SEL_STAT]   = 1'b1;
      default:                        s             = 5'h00;
    endcase
    return s;
  endfunction : reg_sel

  assign regSel  = reg_sel(paddr);
  assign addrHit = |regSel;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      burstWrapOn_r        <= 1'b0;
      burstWrapLengthSel_r <= burst_crc_pkg::WRAP_8;
    end else if (wrEn && pready && regSel[SEL_CFG]) begin
      burstWrapOn_r        <= pwdata[burst_crc_pkg::WRAP_ON_BIT];
      burstWrapLengthSel_r <= burst_crc_pkg::wrap_len_e'(
                                pwdata[burst_crc_pkg::WRAP_LEN_LSB +: 2]);
    end
  end

  // Only bit 0 is stored; upper bits are dropped so they read as zero.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ifaceCrcOffSelect_r <= 1'b0;
    end else if (wrEn && pready && regSel[SEL_ENABLE]) begin
      ifaceCrcOffSelect_r <= pwdata[burst_crc_pkg::CRC_OFF_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arrayIntegrityCrc_r <= burst_crc_pkg::ARRAY_CRC_RESET;
    end else if (arrayCrcLoad) begin
      arrayIntegrityCrc_r <= arrayCrcIn;
    end
  end

  iface_crc_unit u_crc (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .crcOff    (ifaceCrcOffSelect_r),
    .byteValid (linkByteValid),
    .byteData  (linkByte),
    .crcValue  (ifaceCrcCheckValue)
  );

  // ==========================================================================
  // Burst address sequencing
  // ==========================================================================
  // With wrap on, bits outside the wrap group are frozen so the burst never leaves it; with wrap off the address counts up linearly.
  function automatic logic [31:0] next_addr(input logic [31:0] a, input logic wrapOn,
                                            input burst_crc_pkg::wrap_len_e len);
    logic [31:0] mask;
    mask = 32'hffffffff;
    if (wrapOn) begin
      unique case (len)
        burst_crc_pkg::WRAP_8:  mask = 32'h00000007;
        burst_crc_pkg::WRAP_16: mask = 32'h0000000f;
        burst_crc_pkg::WRAP_32: mask = 32'h0000001f;
        burst_crc_pkg::WRAP_64: mask = 32'h0000003f;
      endcase
    end
    return (a & ~mask) | ((a + 32'h00000001) & mask);
  endfunction : next_addr

  burst_crc_pkg::burst_state_e state_r;
  logic [31:0]                 curAddr_r;
  logic [31:0]                 fetchAddr_r;
  logic                        fetchPend_r;
  logic [7:0]                  fifoOut;
  logic                        fifoValid;
  logic                        fifoReady;
  logic                        fifoInReady;
  logic [31:0]                 burstCount_r;
  logic                        issue;

  // One read in flight at a time; a byte is requested only when the FIFO has room.
  assign issue = (state_r == burst_crc_pkg::ST_FETCH) && !fetchPend_r && fifoInReady
                 && !burstStop;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= burst_crc_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        burst_crc_pkg::ST_IDLE: begin
          if (burstStart) begin
            state_r <= burst_crc_pkg::ST_FETCH;
          end
        end
        burst_crc_pkg::ST_FETCH: begin
          if (burstStop) begin
            state_r <= burst_crc_pkg::ST_DRAIN;
          end
        end
        burst_crc_pkg::ST_DRAIN: begin
          state_r <= burst_crc_pkg::ST_IDLE;
        end
        default: state_r <= burst_crc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      curAddr_r <= 32'h00000000;
    end else if (state_r == burst_crc_pkg::ST_IDLE && burstStart) begin
      curAddr_r <= burstAddr;
    end else if (issue) begin
      curAddr_r <= next_addr(curAddr_r, burstWrapOn_r, burstWrapLengthSel_r);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      memAddr     <= 32'h00000000;
      memRead     <= 1'b0;
      fetchPend_r <= 1'b0;
      fetchAddr_r <= 32'h00000000;
    end else begin
      memRead     <= issue;
      fetchPend_r <= issue;
      if (issue) begin
        memAddr     <= curAddr_r;
        fetchAddr_r <= curAddr_r;
      end
    end
  end

  // The array answers while memRead is high; its byte enters the FIFO at the edge that ends
  // the read, so only one read is ever in flight and the room check stays exact.
  byte_fifo #(
    .WIDTH (burst_crc_pkg::FIFO_WIDTH),
    .DEPTH (burst_crc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .flush    (state_r == burst_crc_pkg::ST_DRAIN),
    .inData   (memData),
    .inValid  (memRead),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (fifoReady)
  );

  // Output register stage keeps outputs straight from flip-flops.
  assign fifoReady = !outValid || outReady;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      outByte  <= 8'h00;
      outValid <= 1'b0;
    end else if (state_r == burst_crc_pkg::ST_DRAIN) begin
      outValid <= 1'b0;
    end else if (fifoReady) begin
      outByte  <= fifoOut;
      outValid <= fifoValid;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      outAddr <= 32'h00000000;
    end else if (memRead) begin
      outAddr <= fetchAddr_r;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      burstCount_r <= 32'h00000000;
    end else if (state_r == burst_crc_pkg::ST_IDLE && burstStart) begin
      burstCount_r <= 32'h00000000;
    end else if (outValid && outReady) begin
      burstCount_r <= burstCount_r + 32'h00000001;
    end
  end

  // ==========================================================================
  // APB answer: one wait state, data and ready registered
  // ==========================================================================
  logic [31:0] rdMux;

  always_comb begin
    rdMux = burst_crc_pkg::ERR_ADDR_DATA;
    unique case (paddr)
      burst_crc_pkg::ADDR_BURST_CFG: begin
        rdMux[burst_crc_pkg::WRAP_ON_BIT]       = burstWrapOn_r;
        rdMux[burst_crc_pkg::WRAP_LEN_LSB +: 2] = burstWrapLengthSel_r;
      end
      burst_crc_pkg::ADDR_CRC_ENABLE: rdMux[burst_crc_pkg::CRC_OFF_BIT] = ifaceCrcOffSelect_r;
      burst_crc_pkg::ADDR_CRC_CHECK:  rdMux = ifaceCrcCheckValue;
      burst_crc_pkg::ADDR_ARRAY_CRC:  rdMux = arrayIntegrityCrc_r;
      burst_crc_pkg::ADDR_BURST_STAT: rdMux = burstCount_r;
      default:                        rdMux = burst_crc_pkg::ERR_ADDR_DATA;
    endcase
  end

  // Ready drops right after its pulse; a master that holds the access phase is
  // answered again every second cycle.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !addrHit;
    end
  end

  // Read data is captured in the wait state and then held until the next read.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (rdEn && !pready) begin
      prdata <= rdMux;
    end
  end

endmodule : burst_wrap_and_crc_regs

// ---- tb/burst_crc_chk.sv ----
module burst_crc_chk (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        burstStart,
  input wire logic        burstStop,
  input wire logic [31:0] memAddr,
  input wire logic        memRead,
  input wire logic [7:0]  outByte,
  input wire logic        outValid,
  input wire logic        outReady
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Shadow of the burst setting and the last fetched address
  // ==========================================================
  logic [2:0]  cfg_r;
  logic [31:0] lastAddr_r;
  logic        seen_r;
  logic [31:0] mask;
  logic [31:0] nextAddr;

  assign mask = (32'h8 << cfg_r[1:0]) - 32'h1;
  assign nextAddr = cfg_r[2] ? ((lastAddr_r & ~mask) | ((lastAddr_r + 32'h1) & mask))
                             : lastAddr_r + 32'h1;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      cfg_r <= 3'h0;
    else if (psel && penable && pready && pwrite && paddr == burst_crc_pkg::ADDR_BURST_CFG)
      cfg_r <= {pwdata[burst_crc_pkg::WRAP_ON_BIT], pwdata[1:0]};
  end

  // The first fetch of a burst has no predecessor, so it is not compared.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      seen_r <= 1'b0;
    else if (burstStart || burstStop)
      seen_r <= 1'b0;
    else if (memRead)
      seen_r <= 1'b1;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      lastAddr_r <= 32'h0;
    else if (memRead)
      lastAddr_r <= memAddr;
  end

  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready stayed high for more than one cycle");
  a_access_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access phase not answered after one wait state");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access phase");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without pready or with nonzero data");
  a_reserved_zero: assert property (pready && !pwrite && !pslverr &&
    paddr == burst_crc_pkg::ADDR_CRC_ENABLE |-> prdata[31:1] == 31'h0)
    else $error("reserved enable bits read nonzero");
  a_wrap_next: assert property (memRead && seen_r |-> memAddr == nextAddr)
    else $error("burst fetch address out of sequence");
  a_out_hold: assert property (outValid && !outReady && !burstStop && !$past(burstStop) |=>
    outValid && $stable(outByte))
    else $error("stream byte dropped or changed while stalled");
  a_stop_flush: assert property (burstStop |-> ##2 !outValid && !memRead)
    else $error("stream still active after stop");

  cover property (memRead && seen_r && cfg_r[2]);
  cover property (outValid && !outReady);
  cover property (pslverr);
endmodule : burst_crc_chk

bind burst_wrap_and_crc_regs burst_crc_chk burst_crc_chk_i (
  .clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .burstStart, .burstStop, .memAddr, .memRead, .outByte, .outValid, .outReady
);

// ---- tb/flash_array_model.sv ----
module flash_array_model (
  input  wire logic        memRead,
  input  wire logic [31:0] memAddr,
  output logic      [7:0]  memData
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] pattern;

  // The block takes the byte at the edge that ends its read pulse, so the array answers at once.
  // Outside a read the byte is inverted, so a capture at the wrong time never matches.
  assign pattern = memAddr[7:0] ^ memAddr[15:8];
  assign memData = memRead ? pattern : ~pattern;
endmodule : flash_array_model

// ---- tb/burst_wrap_and_crc_regs_bench.sv ----
module burst_wrap_and_crc_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, memAddr, outAddr;
  logic        pready, pslverr, memRead, outValid;
  logic        burstStart = 1'b0, burstStop = 1'b0, outReady = 1'b0;
  logic [31:0] burstAddr = 32'h0, arrayCrcIn = 32'h0;
  logic [7:0]  memData, outByte, linkByte = 8'h00;
  logic        linkByteValid = 1'b0, arrayCrcLoad = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          errors = 0;
  int          samples_checked = 0;

  burst_wrap_and_crc_regs burst_wrap_and_crc_regs_i (
    .clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .burstStart, .burstAddr, .burstStop, .memAddr, .memRead, .memData,
    .outByte, .outValid, .outReady, .outAddr, .linkByteValid, .linkByte,
    .arrayCrcLoad, .arrayCrcIn
  );
  flash_array_model flash_array_model_i (.memRead, .memAddr, .memData);

  always #5 clk_sys = ~clk_sys;

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One extra edge at the end keeps psel from being driven twice in one step.
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apbXfer

  task automatic readCheck(input logic [7:0] a, input logic [31:0] exp, input string name);
    apbXfer(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : readCheck

  task automatic sendLink();
    repeat (4) begin
      linkByteValid <= 1'b1;
      linkByte <= linkByte + 8'h3c;
      @(posedge clk_sys);
    end
    linkByteValid <= 1'b0;
    @(posedge clk_sys);
  endtask : sendLink

  // The sink stalls one cycle in four; with fill set it first stalls until the FIFO refuses.
  task automatic burst(input logic [2:0] cfg, input logic [31:0] start, input int n,
                       input logic fill);
    int i;
    int c;
    logic [31:0] m;
    logic [31:0] a;
    apbXfer(1'b1, burst_crc_pkg::ADDR_BURST_CFG,
            (32'(cfg[2]) << burst_crc_pkg::WRAP_ON_BIT) | 32'(cfg[1:0]));
    m = (32'h8 << cfg[1:0]) - 32'h1;
    burstAddr <= start;
    burstStart <= 1'b1;
    outReady <= !fill;
    @(posedge clk_sys);
    burstStart <= 1'b0;
    if (fill) begin
      repeat (80) @(posedge clk_sys);
      check("fetch halted with buffer full", {31'h0, memRead}, 32'h0);
      @(posedge clk_sys);
      check("fetch still halted", {31'h0, memRead}, 32'h0);
      check("last fetch address", outAddr, start + 32'(burst_crc_pkg::FIFO_DEPTH));
    end
    i = 0;
    c = 0;
    while (i < n) begin
      @(posedge clk_sys);
      if (outValid === 1'b1 && outReady === 1'b1) begin
        a = cfg[2] ? ((start & ~m) | ((start + i) & m)) : start + i;
        check("stream byte", {24'h0, outByte}, {24'h0, a[7:0] ^ a[15:8]});
        i++;
      end
      c++;
      outReady <= (c % 4) != 0 && i < n;
    end
    burstStop <= 1'b1;
    @(posedge clk_sys);
    burstStop <= 1'b0;
    repeat (3) @(posedge clk_sys);
    readCheck(burst_crc_pkg::ADDR_BURST_STAT, 32'(n), "bytes delivered");
  endtask : burst

  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    #200000;
    errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    readCheck(burst_crc_pkg::ADDR_CRC_ENABLE, 32'h0, "crc enable reset");
    readCheck(burst_crc_pkg::ADDR_CRC_CHECK, 32'h0fffffff, "check value reset");
    readCheck(burst_crc_pkg::ADDR_ARRAY_CRC, 32'h0, "array crc reset");
    apbXfer(1'b1, burst_crc_pkg::ADDR_CRC_ENABLE, 32'h1);
    readCheck(burst_crc_pkg::ADDR_CRC_ENABLE, 32'h1, "crc off readback");
    sendLink();
    readCheck(burst_crc_pkg::ADDR_CRC_CHECK, 32'h0fffffff, "check held while off");
    apbXfer(1'b1, burst_crc_pkg::ADDR_CRC_CHECK, 32'h12345678);
    readCheck(burst_crc_pkg::ADDR_CRC_CHECK, 32'h0fffffff, "check value read only");
    apbXfer(1'b1, burst_crc_pkg::ADDR_CRC_ENABLE, 32'h0);
    sendLink();
    apbXfer(1'b0, burst_crc_pkg::ADDR_CRC_CHECK, 32'h0);
    check("check runs while on", {31'h0, rd !== 32'h0fffffff}, 32'h1);
    apbXfer(1'b1, burst_crc_pkg::ADDR_ARRAY_CRC, 32'hdeadbeef);
    readCheck(burst_crc_pkg::ADDR_ARRAY_CRC, 32'h0, "array crc read only");
    arrayCrcIn <= 32'h5a5a1234;
    arrayCrcLoad <= 1'b1;
    @(posedge clk_sys);
    arrayCrcLoad <= 1'b0;
    @(posedge clk_sys);
    readCheck(burst_crc_pkg::ADDR_ARRAY_CRC, 32'h5a5a1234, "array crc loaded");
    apbXfer(1'b0, 8'h20, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    burst(3'b011, 32'h00001203, 40, 1'b1);
    burst(3'b100, 32'h00001207, 12, 1'b0);
    burst(3'b101, 32'h0000120c, 20, 1'b0);
    burst(3'b110, 32'h0000121e, 36, 1'b0);
    burst(3'b111, 32'h0000122e, 70, 1'b0);
    test_done();
  end
endmodule : burst_wrap_and_crc_regs_bench
